// ### core/acs_pkg.sv
// shared constants and types for the conversion start block
package acs_pkg;

  // ==========================================================
  // register indexes on the register port
  localparam logic [7:0] ACS_IDX_CTRL = 8'h00;
  localparam logic [7:0] ACS_IDX_VIN = 8'h01;
  localparam logic [7:0] ACS_IDX_VOUT = 8'h02;
  localparam logic [7:0] ACS_IDX_IOUT_MEAS = 8'h03;
  localparam logic [7:0] ACS_IDX_IOUT_REG = 8'h04;

  // ==========================================================
  // conversion_start_control field layout
  localparam int ACS_GO_BIT = 0;
  localparam int ACS_MODE_BIT = 1;
  localparam int ACS_SRC_LSB = 5;
  localparam int ACS_SRC_MSB = 6;
  localparam int ACS_FIXED_ONE_BIT = 7;
  localparam logic [15:0] ACS_CTRL_RESET = 16'h0080;
  localparam logic [15:0] ACS_CTRL_FIXED_ONES = 16'h0080;

  // ==========================================================
  // result layout: 12-bit value left aligned, low nibble zero
  localparam int ACS_RES_WIDTH = 12;
  localparam int ACS_RES_SHIFT = 4;
  localparam logic [11:0] ACS_RES_RESET = 12'h000;
  localparam logic [15:0] ACS_RDATA_NONE = 16'h0000;

  // ==========================================================
  // sample sources, encoded as the select field
  localparam logic [1:0] ACS_SRC_VIN = 2'h0;
  localparam logic [1:0] ACS_SRC_VOUT = 2'h1;
  localparam logic [1:0] ACS_SRC_IOUT_MEAS = 2'h2;
  localparam logic [1:0] ACS_SRC_IOUT_REG = 2'h3;
  localparam int ACS_NUM_SRC = 4;

  // converter sequencer states
  typedef enum logic {
    ACS_SEQ_IDLE,
    ACS_SEQ_CONV
  } acs_seq_state_t;

endpackage

// ### core/acs_conv_if.sv
// link between the register front end and the converter sequencer
`timescale 1ns/10ps
`default_nettype none

interface acs_conv_if;
  logic req;
  logic [1:0] chan;
  logic busy;
  logic accept;
  logic [3:0][11:0] result;

  modport ctrl (output req, output chan, input busy, input accept, input result);
  modport seq (input req, input chan, output busy, output accept, output result);
endinterface

`default_nettype wire

// ### core/acs_conv_seq.sv
// converter sequencer: launches one conversion and stores its result
`timescale 1ns/10ps
`default_nettype none

module acs_conv_seq (
  input wire logic ref_clk,
  input wire logic rst_n,
  acs_conv_if.seq link,
  output logic adc_start,
  output logic [1:0] adc_chan,
  input wire logic adc_done,
  input wire logic [11:0] adc_data
);

  acs_pkg::acs_seq_state_t state_q;
  logic [1:0] chan_q;
  logic [3:0][11:0] result_q;

  // ==========================================================
  // handshake with the front end
  assign link.accept = link.req && (state_q == acs_pkg::ACS_SEQ_IDLE);
  assign link.busy = (state_q == acs_pkg::ACS_SEQ_CONV);
  assign link.result = result_q;
  assign adc_chan = chan_q;

  // state: idle until accepted, converting until done
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= acs_pkg::ACS_SEQ_IDLE;
    end else begin
      unique case (state_q)
        acs_pkg::ACS_SEQ_IDLE: begin
          if (link.req) begin
            state_q <= acs_pkg::ACS_SEQ_CONV;
          end
        end
        acs_pkg::ACS_SEQ_CONV: begin
          if (adc_done) begin
            state_q <= acs_pkg::ACS_SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // start pulse and channel held for the conversion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_start <= 1'b0;
      chan_q <= acs_pkg::ACS_SRC_VIN;
    end else begin
      adc_start <= link.accept;
      if (link.accept) begin
        chan_q <= link.chan;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (adc_done && (state_q == acs_pkg::ACS_SEQ_CONV)) begin
      result_q[chan_q] <= adc_data;
    end
  end

endmodule

`default_nettype wire

// ### core/acs_conversion_start.sv
// conversion start control: register front end and trigger logic
`timescale 1ns/10ps
`default_nettype none

module acs_conversion_start (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic adc_start,
  output logic [1:0] adc_chan,
  input wire logic adc_done,
  input wire logic [11:0] adc_data
);

  acs_conv_if conv ();

  logic [1:0] src_sel_q;
  logic manual_q;
  logic pend_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [7:0] src_idx;
  logic rd_trigger;
  logic wr_trigger;
  logic auto_trigger;
  logic go_state;
  logic [15:0] ctrl_view;

  // ==========================================================
  // converter sequencer
  acs_conv_seq u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .link(conv.seq),
    .adc_start(adc_start),
    .adc_chan(adc_chan),
    .adc_done(adc_done),
    .adc_data(adc_data)
  );

  // ==========================================================
  // control fields
  // result register index for the selected source
  always_comb begin
    unique case (src_sel_q)
      acs_pkg::ACS_SRC_VIN: src_idx = acs_pkg::ACS_IDX_VIN;
      acs_pkg::ACS_SRC_VOUT: src_idx = acs_pkg::ACS_IDX_VOUT;
      acs_pkg::ACS_SRC_IOUT_MEAS: src_idx = acs_pkg::ACS_IDX_IOUT_MEAS;
      acs_pkg::ACS_SRC_IOUT_REG: src_idx = acs_pkg::ACS_IDX_IOUT_REG;
    endcase
  end

  // only select and mode bits are stored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_sel_q <= acs_pkg::ACS_CTRL_RESET[acs_pkg::ACS_SRC_MSB:acs_pkg::ACS_SRC_LSB];
      manual_q <= acs_pkg::ACS_CTRL_RESET[acs_pkg::ACS_MODE_BIT];
    end else if (reg_wr && (reg_addr == acs_pkg::ACS_IDX_CTRL)) begin
      src_sel_q <= reg_wdata[acs_pkg::ACS_SRC_MSB:acs_pkg::ACS_SRC_LSB];
      manual_q <= reg_wdata[acs_pkg::ACS_MODE_BIT];
    end
  end

  // ==========================================================
  // trigger sources
  // read of the selected result in manual mode
  assign rd_trigger = reg_rd && manual_q && (reg_addr == src_idx);
  // writing the progress bit as 1 also launches one
  assign wr_trigger = reg_wr && (reg_addr == acs_pkg::ACS_IDX_CTRL) && reg_wdata[acs_pkg::ACS_GO_BIT];
  // automatic mode keeps converting while idle
  assign auto_trigger = !manual_q && !conv.busy && !pend_q;

  // pending request, a new trigger wins over acceptance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (rd_trigger || wr_trigger || auto_trigger) begin
      pend_q <= 1'b1;
    end else if (conv.accept) begin
      pend_q <= 1'b0;
    end
  end

  assign conv.req = pend_q;
  assign conv.chan = src_sel_q;

  // progress bit covers pending and running conversion
  assign go_state = pend_q || conv.busy;

  always_comb begin
    ctrl_view = acs_pkg::ACS_CTRL_FIXED_ONES;
    ctrl_view[acs_pkg::ACS_SRC_MSB:acs_pkg::ACS_SRC_LSB] = src_sel_q;
    ctrl_view[acs_pkg::ACS_MODE_BIT] = manual_q;
    ctrl_view[acs_pkg::ACS_GO_BIT] = go_state;
  end

  // ==========================================================
  // read path, answered one cycle after the strobe
  // stored result shown, stale on the triggering read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= acs_pkg::ACS_RDATA_NONE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          acs_pkg::ACS_IDX_CTRL: rdata_q <= ctrl_view;
          acs_pkg::ACS_IDX_VIN: rdata_q <= {conv.result[acs_pkg::ACS_SRC_VIN], 4'h0};
          acs_pkg::ACS_IDX_VOUT: rdata_q <= {conv.result[acs_pkg::ACS_SRC_VOUT], 4'h0};
          acs_pkg::ACS_IDX_IOUT_MEAS: rdata_q <= {conv.result[acs_pkg::ACS_SRC_IOUT_MEAS], 4'h0};
          acs_pkg::ACS_IDX_IOUT_REG: rdata_q <= {conv.result[acs_pkg::ACS_SRC_IOUT_REG], 4'h0};
          default: rdata_q <= acs_pkg::ACS_RDATA_NONE;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

endmodule

`default_nettype wire

// ### test/acs_conversion_start_properties.sv
// timing checker for the conversion start block
`timescale 1ns/10ps
`default_nettype none
module acs_conversion_start_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic adc_start,
  input wire logic [1:0] adc_chan,
  input wire logic adc_done,
  input wire logic [11:0] adc_data
);
  logic mode_q;
  logic [1:0] sel_q;
  // ==========================================
  // shadow of mode and source select
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
      sel_q <= 2'h0;
    end else if (reg_wr && reg_addr == acs_pkg::ACS_IDX_CTRL) begin
      mode_q <= reg_wdata[1];
      sel_q <= reg_wdata[6:5];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h04 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ctrl_fixed_bits: assert property (reg_rd && reg_addr == 8'h00 |=> (reg_rdata & 16'hff9c) == 16'h0080)
    else $error("control fixed bits wrong");
  a_result_nibble_zero: assert property (reg_rd && reg_addr inside {[8'h01:8'h04]} |=> reg_rdata[3:0] == 4'h0)
    else $error("result low bits not zero");
  a_start_pulse: assert property (adc_start |=> !adc_start) else $error("start longer than a cycle");
  a_trigger_start: assert property (reg_rd && mode_q && reg_addr == {6'h00, sel_q} + 8'h01 |-> ##[2:12] adc_start)
    else $error("trigger read did not start");
  a_chan_select: assert property (adc_start && mode_q |-> adc_chan == sel_q) else $error("wrong channel");
  c_chan_three: cover property (adc_start && adc_chan == 2'h3);
  c_unmapped: cover property (reg_rd && reg_addr > 8'h04);
  c_busy_seen: cover property (reg_rvalid && reg_rdata[0]);
endmodule
bind acs_conversion_start acs_conversion_start_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));
`default_nettype wire

// ### test/test_acs_conversion_start.sv
// self-checking bench for the conversion start block
`timescale 1ns/10ps
`default_nettype none
module test_acs_conversion_start;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic adc_start;
  logic [1:0] adc_chan;
  logic adc_done = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic [31:0] seed = 32'h0000_9223;
  logic [15:0] res [4] = '{default: 16'h0000};
  logic [15:0] v;
  logic [1:0] ch;
  int w;
  int n_mismatch = 0;
  int tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  acs_conversion_start u_acs_conversion_start (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int i;
    @(posedge ref_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 4) begin
      n_mismatch++;
      conclude();
    end
    d = reg_rdata;
  endtask
  // converter stand-in: answers each start three cycles later
  initial forever begin
    @(posedge ref_clk);
    if (adc_start === 1'b1) begin
      ch = adc_chan;
      repeat (3) @(posedge ref_clk);
      #1 seed = xs(seed);
      adc_data = seed[11:0];
      adc_done = 1'b1;
      res[ch] = {seed[11:0], 4'h0};
      @(posedge ref_clk);
      #1 adc_done = 1'b0;
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    wr(acs_pkg::ACS_IDX_CTRL, 16'hff1e);
    repeat (20) @(posedge ref_clk);
    rd(acs_pkg::ACS_IDX_CTRL, v);
    chk("ctrl", v, 16'h0082);
    for (int s = 0; s < 4; s++) begin
      wr(acs_pkg::ACS_IDX_CTRL, 16'h0002 | (16'(s) << 5));
      rd(8'(s + 1), v);
      chk("trigger read", v, res[s]);
      rd(acs_pkg::ACS_IDX_CTRL, v);
      chk("busy", v, 16'h0083 | (16'(s) << 5));
      repeat (20) @(posedge ref_clk);
      rd(acs_pkg::ACS_IDX_CTRL, v);
      chk("idle", v, 16'h0082 | (16'(s) << 5));
      rd(8'(s + 1), v);
      chk("result", v, res[s]);
      repeat (20) @(posedge ref_clk);
    end
    rd(8'h07, v);
    chk("unmapped", v, 16'h0000);
    // power train stop and restart lie outside this block, setup sits between them
    wr(acs_pkg::ACS_IDX_CTRL, 16'h0081);
    // wait for a start so the read lands inside a conversion, not in the idle gap
    for (w = 0; w < 40 && adc_start !== 1'b1; w++) begin
      @(posedge ref_clk);
      #1;
    end
    if (w == 40) n_mismatch++;
    rd(acs_pkg::ACS_IDX_CTRL, v);
    chk("auto busy", v, 16'h0081);
    conclude();
  end
endmodule
`default_nettype wire
